//--- rtl/sc_timer_pkg.sv
// Shared constants, types and mode table for the card pin and ETU timer block
package sc_timer_pkg;

   // Register bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register offsets (byte addresses)
   localparam logic [7:0] ETU_DIV_OFF  = 8'h20;
   localparam logic [7:0] PIN_CTRL_OFF = 8'h24;
   localparam logic [7:0] TMR0_OFF     = 8'h28;
   localparam logic [7:0] TMR1_OFF     = 8'h2C;

   // Card pin control field positions
   localparam int PIN_PWR_CTRL_BIT = 0;
   localparam int PIN_RST_CTRL_BIT = 1;
   localparam int PIN_PWR_INV_BIT  = 11;
   localparam int PIN_PWR_STS_BIT  = 17;
   localparam int PIN_RST_STS_BIT  = 18;

   // Timer control field positions and widths
   localparam int TMR_SYNC_BIT = 31;
   localparam int TMR_MODE_LSB = 24;
   localparam int TMR_MODE_W   = 4;
   localparam int TMR0_W       = 24;
   localparam int TMR1_W       = 8;

   // Reset values and timing counts
   localparam logic [31:0] TMR_RESET     = 32'h0000_0000;
   localparam int          ETU_W         = 12;
   localparam logic [11:0] ETU_DIV_RESET = 12'h173;
   localparam logic [1:0]  SYNC_CYCLES   = 2'h3;

   // Register bus request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } reg_req_t;

   // Pin sequencer takeover
   typedef struct packed {
      logic active;
      logic rst_level;
      logic pwr_ctrl;
   } pin_seq_t;

   // Decoded timer behaviour
   typedef struct packed {
      logic run;
      logic down;
      logic reload;
   } timer_mode_t;

   // Mode encoding table, indexed by the operation select field
   localparam timer_mode_t MODE_TABLE [16] = '{
      3'b000, 3'b110, 3'b111, 3'b100, 3'b000, 3'b000, 3'b000, 3'b000,
      3'b000, 3'b000, 3'b000, 3'b000, 3'b000, 3'b000, 3'b000, 3'b000};

   // Top-level state
   typedef struct packed {
      logic [31:0] rd_data;
      logic        rst_pin;
      logic        pwr_ctrl;
      logic        pwr_inv;
      logic        pwr_pin;
      logic [11:0] etu_div;
      logic [11:0] etu_cnt;
      logic        etu_tick;
      logic [1:0]  sync0;
      logic [1:0]  sync1;
      logic [31:0] pend0;
      logic [31:0] pend1;
      logic        load0;
      logic        load1;
   } top_state_t;

endpackage

//--- rtl/sc_etu_timer.sv
// One ETU-based timer with table-driven mode decoding
`timescale 1ns/1ps
module sc_etu_timer #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk_sys_in,
   input  wire logic         reset_in,
   // Control
   input  wire logic         tick_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] load_count_in,
   input  wire logic [3:0]   load_mode_in,
   // State
   output logic [W-1:0]      count_out,
   output logic [3:0]        mode_out
);
   import sc_timer_pkg::*;

   typedef struct packed {
      logic [W-1:0] count;
      logic [W-1:0] reload;
      logic [3:0]   mode;
   } timer_state_t;

   timer_state_t q;
   timer_state_t d;
   timer_mode_t  m;

   // Next state: load wins over counting, counting only on an ETU tick
   always_comb begin
      d = q;
      m = MODE_TABLE[q.mode];
      if (load_in) begin
         d.count  = load_count_in;
         d.reload = load_count_in;
         d.mode   = load_mode_in;
      end else if (tick_in && m.run) begin
         if (!m.down) begin
            d.count = W'(q.count + 1'b1);
         end else if (q.count == '0) begin
            if (m.reload) begin
               d.count = q.reload;
            end
         end else begin
            d.count = W'(q.count - 1'b1);
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign count_out = q.count;
   assign mode_out  = q.mode;

endmodule // sc_etu_timer

//--- rtl/sc_pin_etu_timers.sv
// Card reset/power pin control and the two ETU timers with register access
`timescale 1ns/1ps
module sc_pin_etu_timers #(
   parameter int T0_W = 24,
   parameter int T1_W = 8
) (
   // Clock and reset
   input  wire logic                  clk_sys_in,
   input  wire logic                  reset_in,
   // Register port
   input  sc_timer_pkg::reg_req_t     reg_req_in,
   output logic [31:0]                rd_data_out,
   // Activation/deactivation sequencer takeover
   input  sc_timer_pkg::pin_seq_t     seq_in,
   // Card pins
   output logic                       card_reset_pin_out,
   output logic                       card_power_pin_out
);
   import sc_timer_pkg::*;

   top_state_t        q;
   top_state_t        d;
   logic [T0_W-1:0]   t0_count;
   logic [T1_W-1:0]   t1_count;
   logic [3:0]        t0_mode;
   logic [3:0]        t1_mode;
   logic              wr_pin;
   logic              wr_t0;
   logic              wr_t1;
   logic              busy0;
   logic              busy1;

   // Compose a timer control word; reserved bits read as zero
   function automatic logic [31:0] timer_word(input logic busy, input logic [3:0] mode,
                                              input logic [23:0] count);
      logic [31:0] w;
      w = TMR_RESET;
      w[TMR_SYNC_BIT] = busy;
      w[TMR_MODE_LSB +: TMR_MODE_W] = mode;
      w[23:0] = count;
      return w;
   endfunction

   // Sync counter step: start on an accepted write, then count down
   function automatic logic [1:0] sync_step(input logic start, input logic [1:0] cnt);
      logic [1:0] n;
      n = cnt;
      if (start) begin
         n = SYNC_CYCLES;
      end else if (cnt != 2'h0) begin
         n = cnt - 2'h1;
      end
      return n;
   endfunction

   // Register decode: a strobe aimed at one offset
   function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
                                    input logic [7:0] off);
      return strobe && (addr == off);
   endfunction

   // Address decode and busy flags
   assign wr_pin = reg_hit(reg_req_in.wr, reg_req_in.addr, PIN_CTRL_OFF);
   assign busy0  = (q.sync0 != 2'h0) || q.load0;
   assign busy1  = (q.sync1 != 2'h0) || q.load1;
   assign wr_t0  = reg_hit(reg_req_in.wr, reg_req_in.addr, TMR0_OFF) && !busy0;
   assign wr_t1  = reg_hit(reg_req_in.wr, reg_req_in.addr, TMR1_OFF) && !busy1;

   // Next state of pins, ETU divider, sync staging and read data
   always_comb begin
      d = q;
      // Pin control: sequencer takes the bits over while it runs
      if (seq_in.active) begin
         d.rst_pin  = seq_in.rst_level;
         d.pwr_ctrl = seq_in.pwr_ctrl;
      end else if (wr_pin) begin
         d.rst_pin  = reg_req_in.wdata[PIN_RST_CTRL_BIT];
         d.pwr_ctrl = reg_req_in.wdata[PIN_PWR_CTRL_BIT];
         d.pwr_inv  = reg_req_in.wdata[PIN_PWR_INV_BIT];
      end
      d.pwr_pin = d.pwr_inv ^ d.pwr_ctrl;
      // ETU divider register
      if (reg_hit(reg_req_in.wr, reg_req_in.addr, ETU_DIV_OFF)) begin
         d.etu_div = reg_req_in.wdata[ETU_W-1:0];
      end
      // ETU tick: one pulse every etu_div+1 system cycles
      d.etu_tick = (q.etu_cnt == '0);
      d.etu_cnt  = (q.etu_cnt == '0) ? q.etu_div : q.etu_cnt - 12'h001;
      // Timer writes are staged while the new value synchronises
      if (wr_t0) begin
         d.pend0 = reg_req_in.wdata;
      end
      if (wr_t1) begin
         d.pend1 = reg_req_in.wdata;
      end
      d.sync0 = sync_step(wr_t0, q.sync0);
      d.sync1 = sync_step(wr_t1, q.sync1);
      d.load0 = (q.sync0 == 2'h1);
      d.load1 = (q.sync1 == 2'h1);
      // Read data stands in the cycle after the read strobe only
      d.rd_data = '0;
      if (reg_req_in.rd) begin
         unique case (reg_req_in.addr)
            ETU_DIV_OFF: d.rd_data[ETU_W-1:0] = q.etu_div;
            PIN_CTRL_OFF: begin
               d.rd_data[PIN_RST_CTRL_BIT] = q.rst_pin;
               d.rd_data[PIN_PWR_CTRL_BIT] = q.pwr_pin;
               d.rd_data[PIN_PWR_INV_BIT]  = q.pwr_inv;
               d.rd_data[PIN_PWR_STS_BIT]  = q.pwr_pin;
               d.rd_data[PIN_RST_STS_BIT]  = q.rst_pin;
            end
            TMR0_OFF: d.rd_data = timer_word(busy0, t0_mode, 24'(t0_count));
            TMR1_OFF: d.rd_data = timer_word(busy1, t1_mode, 24'(t1_count));
            default: d.rd_data = '0;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         q         <= '0;
         q.etu_div <= ETU_DIV_RESET;
         q.etu_cnt <= ETU_DIV_RESET;
         q.pend0   <= TMR_RESET;
         q.pend1   <= TMR_RESET;
      end else begin
         q <= d;
      end
   end

   // Timer0: 24-bit ETU counter
   sc_etu_timer #(.W(T0_W)) u_timer0 (
      .clk_sys_in    (clk_sys_in),
      .reset_in      (reset_in),
      .tick_in       (q.etu_tick),
      .load_in       (q.load0),
      .load_count_in (q.pend0[T0_W-1:0]),
      .load_mode_in  (q.pend0[TMR_MODE_LSB +: TMR_MODE_W]),
      .count_out     (t0_count),
      .mode_out      (t0_mode)
   );

   // Timer1: 8-bit ETU counter
   sc_etu_timer #(.W(T1_W)) u_timer1 (
      .clk_sys_in    (clk_sys_in),
      .reset_in      (reset_in),
      .tick_in       (q.etu_tick),
      .load_in       (q.load1),
      .load_count_in (q.pend1[T1_W-1:0]),
      .load_mode_in  (q.pend1[TMR_MODE_LSB +: TMR_MODE_W]),
      .count_out     (t1_count),
      .mode_out      (t1_mode)
   );

   // Outputs straight from flops
   assign rd_data_out        = q.rd_data;
   assign card_reset_pin_out = q.rst_pin;
   assign card_power_pin_out = q.pwr_pin;

   // Checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   logic rd_pin;
   logic rd_t0;
   logic rd_t1;
   assign rd_pin = reg_hit(reg_req_in.rd, reg_req_in.addr, PIN_CTRL_OFF);
   assign rd_t0  = reg_hit(reg_req_in.rd, reg_req_in.addr, TMR0_OFF);
   assign rd_t1  = reg_hit(reg_req_in.rd, reg_req_in.addr, TMR1_OFF);

   AST_RST_WRITE: assert property (
      wr_pin && !seq_in.active
      |=> card_reset_pin_out == $past(reg_req_in.wdata[PIN_RST_CTRL_BIT]))
      else $error("reset pin does not follow written control bit");

   AST_RST_READ: assert property (
      rd_pin |=> rd_data_out[PIN_RST_CTRL_BIT] == $past(card_reset_pin_out))
      else $error("reset control read does not show pin level");

   AST_SEQ_OWNS: assert property (
      seq_in.active |=> card_reset_pin_out == $past(seq_in.rst_level))
      else $error("sequencer did not drive reset pin");

   AST_PWR_WRITE: assert property (
      wr_pin && !seq_in.active
      |=> card_power_pin_out == ($past(reg_req_in.wdata[PIN_PWR_INV_BIT])
                                 ^ $past(reg_req_in.wdata[PIN_PWR_CTRL_BIT])))
      else $error("power pin does not follow written bits");

   AST_PWR_XOR: assert property (
      ##1 card_power_pin_out == (q.pwr_inv ^ q.pwr_ctrl))
      else $error("power pin is not invert xor control");

   AST_PWR_READ: assert property (
      rd_pin |=> rd_data_out[PIN_PWR_CTRL_BIT] == $past(card_power_pin_out))
      else $error("power control read does not show pin level");

   AST_SYNC_FLAG: assert property (
      wr_t0 ##[1:4] rd_t0 |=> rd_data_out[TMR_SYNC_BIT])
      else $error("sync flag not set after timer write");

   AST_SYNC_LEN: assert property (
      wr_t0 |=> busy0 [*4] ##1 !busy0)
      else $error("sync flag duration wrong");

   AST_T0_LOAD: assert property (
      wr_t0 |-> ##5 t0_count == $past(reg_req_in.wdata[23:0], 5))
      else $error("timer0 count not loaded after sync");

   AST_T0_MODE: assert property (
      q.load0 |=> t0_mode == $past(q.pend0[27:24]))
      else $error("timer0 mode not loaded");

   AST_RSVD: assert property (
      rd_t1 |=> rd_data_out[30:28] == 3'h0 && rd_data_out[23:8] == 16'h0000)
      else $error("reserved timer1 bits not zero");

   AST_T0_ETU: assert property (
      !q.etu_tick && !q.load0 |=> $stable(t0_count))
      else $error("timer0 moved without ETU tick");

   AST_T1_ETU: assert property (
      !q.etu_tick && !q.load1 |=> $stable(t1_count))
      else $error("timer1 moved without ETU tick");

   AST_T1_TABLE: assert property (
      q.etu_tick && !q.load1 && MODE_TABLE[t1_mode].run && MODE_TABLE[t1_mode].down
      && t1_count != '0 |=> t1_count == T1_W'($past(t1_count) - 1'b1))
      else $error("timer1 down count wrong");

   // Timer counting, reload, load and reserved-bit checks
   AST_T0_UP: assert property (
      q.etu_tick && !q.load0 && MODE_TABLE[t0_mode].run && !MODE_TABLE[t0_mode].down
      |=> t0_count == T0_W'($past(t0_count) + 1'b1))
      else $error("timer0 did not advance one count per ETU");

   AST_T1_UP: assert property (
      q.etu_tick && !q.load1 && MODE_TABLE[t1_mode].run && !MODE_TABLE[t1_mode].down
      |=> t1_count == T1_W'($past(t1_count) + 1'b1))
      else $error("timer1 did not advance one count per ETU");

   AST_T1_HOLD: assert property (
      q.etu_tick && !q.load1 && MODE_TABLE[t1_mode].run && MODE_TABLE[t1_mode].down
      && !MODE_TABLE[t1_mode].reload && t1_count == '0 |=> t1_count == '0)
      else $error("timer1 left zero in a hold mode");

   AST_T1_RELOAD: assert property (
      q.etu_tick && !busy1 && MODE_TABLE[t1_mode].run && MODE_TABLE[t1_mode].down
      && MODE_TABLE[t1_mode].reload && t1_count == '0
      |=> t1_count == $past(q.pend1[T1_W-1:0]))
      else $error("timer1 did not reload its loaded value");

   AST_T1_LOAD: assert property (
      wr_t1 |-> ##5 t1_count == $past(reg_req_in.wdata[T1_W-1:0], 5))
      else $error("timer1 count not loaded after sync");

   AST_T1_MODE: assert property (
      q.load1 |=> t1_mode == $past(q.pend1[TMR_MODE_LSB +: TMR_MODE_W]))
      else $error("timer1 mode not loaded");

   AST_T0_RSVD: assert property (
      rd_t0 |=> rd_data_out[30:28] == 3'h0)
      else $error("reserved timer0 bits not zero");

   // Refused writes and status read-back
   AST_T0_REFUSE: assert property (
      busy0 && reg_req_in.wr && reg_req_in.addr == TMR0_OFF |=> $stable(q.pend0))
      else $error("timer0 write taken while synchronising");

   AST_PIN_REFUSE: assert property (
      seq_in.active && wr_pin |=> $stable(q.pwr_inv))
      else $error("pin control write taken while sequencer runs");

   AST_SEQ_PWR: assert property (
      seq_in.active |=> q.pwr_ctrl == $past(seq_in.pwr_ctrl))
      else $error("sequencer did not set power control");

   AST_PWR_STS: assert property (
      rd_pin |=> rd_data_out[PIN_PWR_STS_BIT] == $past(card_power_pin_out))
      else $error("power status read does not show pin level");

   AST_RST_STS: assert property (
      rd_pin |=> rd_data_out[PIN_RST_STS_BIT] == $past(card_reset_pin_out))
      else $error("reset status read does not show pin level");

   AST_RD_IDLE: assert property (
      !reg_req_in.rd |=> rd_data_out == '0)
      else $error("read data shown without a read strobe");

   COV_SEQ: cover property (seq_in.active ##1 !seq_in.active);
   COV_T0_RUN: cover property (q.load0 ##1 MODE_TABLE[t0_mode].run ##[1:1000] q.etu_tick);
   COV_T1_RELOAD: cover property (t1_count == '0 && MODE_TABLE[t1_mode].reload && q.etu_tick);
   COV_BUSY_WRITE: cover property (busy0 && reg_req_in.wr && reg_req_in.addr == TMR0_OFF);
   COV_PIN_REFUSED: cover property (seq_in.active && wr_pin);

endmodule // sc_pin_etu_timers

//--- verification/card_contact_model.sv
// Behavioural smart card contact model watching the reset and power pins
`timescale 1ns/1ps
module card_contact_model (
   // Card contacts
   input  wire logic card_reset_pin_in,
   input  wire logic card_power_pin_in,
   // Observed card state
   output logic      powered_out,
   output logic      held_in_reset_out
);
   // The card sees supply and reset as plain levels on its contacts
   assign powered_out       = card_power_pin_in;
   assign held_in_reset_out = card_power_pin_in & ~card_reset_pin_in;
endmodule // card_contact_model

//--- verification/test_smartcard_pin_and_etu_timers.sv
// Self-checking bench for the card pin and ETU timer block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("BAD %0t got %h expected %h", $time, (a), (e)); end end
module test_smartcard_pin_and_etu_timers;
   import sc_timer_pkg::*;
   logic        clk_sys_in   = 1'b0;
   logic        reset_in     = 1'b1;
   reg_req_t    req          = '0;
   pin_seq_t    seq          = '0;
   logic [31:0] rd_data;
   logic        rst_pin;
   logic        pwr_pin;
   logic        card_powered;
   logic        card_held;
   int          miscompares  = 0;
   int          total_checks = 0;

   // Clock at 100 MHz
   always #5 clk_sys_in = ~clk_sys_in;

   sc_pin_etu_timers #(.T0_W(24), .T1_W(8)) dut (
      .clk_sys_in         (clk_sys_in),
      .reset_in           (reset_in),
      .reg_req_in         (req),
      .rd_data_out        (rd_data),
      .seq_in             (seq),
      .card_reset_pin_out (rst_pin),
      .card_power_pin_out (pwr_pin)
   );

   card_contact_model card (
      .card_reset_pin_in (rst_pin),
      .card_power_pin_in (pwr_pin),
      .powered_out       (card_powered),
      .held_in_reset_out (card_held)
   );

   // One-cycle register write
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      req.wr    <= 1'b1;
      req.addr  <= a;
      req.wdata <= d;
      @(posedge clk_sys_in);
      req.wr <= 1'b0;
   endtask

   // One-cycle register read, data taken in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      req.rd   <= 1'b1;
      req.addr <= a;
      @(posedge clk_sys_in);
      req.rd <= 1'b0;
      #1 d = rd_data;
   endtask

   // Poll a timer register until its last write has settled
   task automatic wait_sync(input logic [7:0] a);
      logic [31:0] d;
      int          n;
      n = 0;
      do begin
         rd_reg(a, d);
         n++;
      end while (d[31] && n < 20);
      `CHK(d[31], 1'b0)
   endtask

   // Reset values, pins low and an unmapped read
   task automatic t_reset_values();
      logic [31:0] d;
      rd_reg(TMR0_OFF, d);
      `CHK(d, TMR_RESET)
      rd_reg(TMR1_OFF, d);
      `CHK(d, TMR_RESET)
      rd_reg(PIN_CTRL_OFF, d);
      `CHK(d, 32'h0000_0000)
      rd_reg(8'h40, d);
      `CHK(d, 32'h0000_0000)
      `CHK({rst_pin, pwr_pin}, 2'b00)
      $display("test reset_values done");
   endtask

   // Every invert, reset and power combination, pins and read-back
   task automatic t_pins();
      logic [31:0] d;
      logic        p;
      for (int i = 0; i < 8; i++) begin
         wr_reg(PIN_CTRL_OFF, {20'h0_0000, i[2], 9'h000, i[1], i[0]});
         p = i[2] ^ i[0];
         rd_reg(PIN_CTRL_OFF, d);
         `CHK(pwr_pin, p)
         `CHK(rst_pin, i[1])
         `CHK(card_held, p & ~i[1])
         `CHK({d[18:17], d[11], d[1:0]}, {i[1], p, i[2], i[1], p})
      end
      $display("test pins done");
   endtask

   // Sequencer owns the pins and software writes are refused meanwhile
   task automatic t_sequencer();
      logic [31:0] d;
      wr_reg(PIN_CTRL_OFF, 32'h0000_0800); // invert chosen first
      @(posedge clk_sys_in);
      seq <= '{active: 1'b1, rst_level: 1'b1, pwr_ctrl: 1'b1};
      wr_reg(PIN_CTRL_OFF, 32'h0000_0001);
      rd_reg(PIN_CTRL_OFF, d);
      `CHK({rst_pin, pwr_pin}, 2'b10)
      `CHK(d[1:0], 2'b10)
      @(posedge clk_sys_in);
      seq <= '0;
      wr_reg(PIN_CTRL_OFF, 32'h0000_0002);
      rd_reg(PIN_CTRL_OFF, d);
      `CHK({rst_pin, pwr_pin, card_powered}, 3'b100)
      $display("test sequencer done");
   endtask

   // Sync flag while a write settles, a write refused meanwhile
   task automatic t_sync();
      logic [31:0] d;
      wait_sync(TMR0_OFF);
      wr_reg(TMR0_OFF, 32'h0012_3456);
      wr_reg(TMR0_OFF, 32'h00AB_CDEF);
      rd_reg(TMR0_OFF, d);
      `CHK(d[31], 1'b1)
      wait_sync(TMR0_OFF);
      rd_reg(TMR0_OFF, d);
      `CHK(d, 32'h0012_3456)
      $display("test sync done");
   endtask

   // All sixteen mode codes; reserved and read-only bits read zero
   task automatic t_modes();
      logic [31:0] d;
      for (int m = 0; m < 16; m++) begin
         wr_reg(TMR1_OFF, {4'hF, m[3:0], 24'hFF_FF00});
         wait_sync(TMR1_OFF);
         rd_reg(TMR1_OFF, d);
         `CHK(d[31:8], {4'h0, m[3:0], 16'h0000})
      end
      $display("test modes done");
   endtask

   // Count advance over exactly 30 clocks with a tick every 3 clocks
   task automatic rate_pair(input logic [7:0] a, output logic [23:0] diff);
      logic [31:0] x;
      logic [31:0] y;
      rd_reg(a, x);
      repeat (28) @(posedge clk_sys_in);
      rd_reg(a, y);
      diff = y[23:0] - x[23:0];
   endtask

   // Both timers count up once per ETU and wrap at their width
   task automatic t_count_rate();
      logic [23:0] d0;
      logic [23:0] d1;
      wr_reg(ETU_DIV_OFF, 32'h0000_0002);
      // Let the count started from the old divider run out first
      repeat (int'(ETU_DIV_RESET) + 1) @(posedge clk_sys_in);
      wait_sync(TMR0_OFF);
      wr_reg(TMR0_OFF, 32'h03FF_FFFA);
      wait_sync(TMR0_OFF);
      rate_pair(TMR0_OFF, d0);
      `CHK(d0, 24'h00_000A)
      wait_sync(TMR1_OFF);
      wr_reg(TMR1_OFF, 32'h0300_00F8);
      wait_sync(TMR1_OFF);
      rate_pair(TMR1_OFF, d1);
      `CHK(d1[7:0], 8'h0A)
      $display("test count_rate done");
   endtask

   // Timer1 counts down to zero and holds, then reloads its loaded value
   task automatic t_down_reload();
      logic [31:0] d;
      logic [23:0] d1;
      wait_sync(TMR1_OFF);
      wr_reg(TMR1_OFF, 32'h0100_0005);
      wait_sync(TMR1_OFF);
      repeat (60) @(posedge clk_sys_in);
      rd_reg(TMR1_OFF, d);
      `CHK(d, 32'h0100_0000)
      wr_reg(TMR1_OFF, 32'h0200_0004);
      wait_sync(TMR1_OFF);
      rate_pair(TMR1_OFF, d1);
      `CHK(d1[7:0], 8'h00)
      $display("test down_reload done");
   endtask

   // Counts, verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #100_000;
      miscompares++;
      $display("BAD %0t watchdog expired", $time);
      summarize();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      t_reset_values();
      t_pins();
      t_sequencer();
      t_sync();
      t_modes();
      t_count_rate();
      t_down_reload();
      summarize();
   end
endmodule // test_smartcard_pin_and_etu_timers
